// file: verilog/scs_pkg.sv
// Constants, field layout and types for the supervisor control/status block.
// Assumes a 200 MHz core clock; shared by the block and its bench.
package scs_pkg;
  // Serial bus identifiers (upper seven bits of the slave address byte)
  localparam logic [6:0] ID_MEM = 7'h50;
  localparam logic [6:0] ID_CR = 7'h52;
  localparam logic [6:0] ID_DCP = 7'h57;
  localparam logic [7:0] CR_ADDR = 8'hff;
  // Latch command bytes
  localparam logic [7:0] WEL_SET = 8'h02;
  localparam logic [7:0] WEL_CLR = 8'h00;
  localparam logic [7:0] REGISTER_WRITE_LATCH_SET = 8'h06;
  // Control/status bit positions
  localparam int unsigned B_PUP_HI = 7;
  localparam int unsigned B_F2 = 6;
  localparam int unsigned B_F3 = 5;
  localparam int unsigned B_BP_HI = 4;
  localparam int unsigned B_BP_LO = 3;
  localparam int unsigned B_REGISTER_WRITE_LATCH = 2;
  localparam int unsigned B_WEL = 1;
  localparam int unsigned B_PUP_LO = 0;
  // Nonvolatile defaults
  localparam logic [1:0] BP_DEF = 2'h0;
  localparam logic [1:0] PUP_DEF = 2'h1;
  // Protect field codes and region bases
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [7:0] QTR_BASE = 8'hc0;
  localparam logic [7:0] HALF_BASE = 8'h80;
  // Reset delay codes
  localparam logic [1:0] PUP_50 = 2'h0;
  localparam logic [1:0] PUP_100 = 2'h1;
  localparam logic [1:0] PUP_200 = 2'h2;
  // Timing
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned POR_MS_0 = 50;
  localparam int unsigned POR_MS_1 = 100;
  localparam int unsigned POR_MS_2 = 200;
  localparam int unsigned POR_MS_3 = 300;
  localparam int unsigned NV_MS = 5;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] PAGE_STEP = 4'h1;
  // Serial engine state and access target
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_ADDR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_WAIT
  } scs_state_e;
  typedef enum logic [1:0] {TG_NONE, TG_MEM, TG_CR, TG_DCP} scs_tgt_e;
endpackage

// file: verilog/scs_supervisor.sv
// Control/status register, memory array and serial engine of the supervisor.
// Assumes an open-drain serial bus, a sync reset on the core clock and
// asynchronous pins, all of which are synchronised before use.
// What this block does
// - Send another memory byte each time the master acknowledges the last one.
// - Read pointer steps by one per byte and wraps from the top to 00h.
// - Register bits: delay high, fail2, fail3, protect hi/lo, reg latch, latch, delay low.
// - Latches and fail flags come out of power-up as zero.
// - Protect and reset-delay bits survive power cycles.
// - Without the write latch every write except 00000010 to the register is aborted and the data byte unacknowledged.
// - 00000010 sets the write latch, 00000000 clears it, a register write loads it from bit 1; otherwise it holds.
// - Latch-only writes start no programming cycle; next operation accepted at once.
// - Other register bits are written only while the register write latch is set.
// - Register write latch sets only while the write latch is set.
// - Register write latch clears after a register write, power-down or protected write.
// - Protect 00 none, 01 C0h-FFh, 10 80h-FFh, 11 whole array.
// - Writes to protected addresses are aborted and change no byte.
// - Nonzero protect field refuses every wiper write.
// - Protect bits ship as zero.
// - Write-protect high blocks all nonvolatile writes.
// - Delay code 00 50ms, 01 100ms default, 10 200ms, 11 300ms.
// - Reset output stays high until supply is good for the selected delay.
// - Fail flag can be written to one only while its fail input is high.
// - Set fail flag clears when its fail input drops or on power cycle.
// - Register reached at id 1010010, address FFh, one data byte then stop.
// - Bit 2 set in the final write only sets the register latch; else 5ms update.
`timescale 1ns/1ps

module scs_sync #(parameter int W = 1) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clk) begin
    meta_r <= i_d;
    o_q <= meta_r;
  end
endmodule // scs_sync

module scs_supervisor
  import scs_pkg::*;
#(
  parameter int unsigned POR_CYC_0 = POR_MS_0 * CLK_KHZ,
  parameter int unsigned POR_CYC_1 = POR_MS_1 * CLK_KHZ,
  parameter int unsigned POR_CYC_2 = POR_MS_2 * CLK_KHZ,
  parameter int unsigned POR_CYC_3 = POR_MS_3 * CLK_KHZ,
  parameter int unsigned NV_CYC = NV_MS * CLK_KHZ
) (
  // Core clock and resets
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_factory_rstn,
  // Serial link
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Pins from the monitors
  input wire logic i_wp,
  input wire logic i_supply_ok,
  input wire logic i_second_fail_output,
  input wire logic i_third_fail_output,
  // Outputs
  output logic o_reset_out,
  output logic [1:0] o_protect,
  output logic [7:0] o_wiper_pos,
  output logic [7:0] o_control_status
);
  // Link-domain synchronisers
  logic [1:0] lrst_s;
  logic [5:0] lin_s;
  logic lrst_n, lfac_n, scl_s, sda_s, wp_s, fail2_s, fail3_s, busy_s;
  logic busy_c, nv_tog_r;
  logic [1:0] pup_r;
  scs_sync #(.W(2)) u_lrst (.i_clk(i_link_clk), .i_d({i_factory_rstn, i_rstn}), .o_q(lrst_s));
  scs_sync #(.W(6)) u_lin (
    .i_clk(i_link_clk),
    .i_d({i_scl, i_sda, i_wp, i_second_fail_output, i_third_fail_output, busy_c}),
    .o_q(lin_s)
  );
  assign {lfac_n, lrst_n} = lrst_s;
  assign {scl_s, sda_s, wp_s, fail2_s, fail3_s, busy_s} = lin_s;

  // Core-domain synchronisers
  logic [3:0] cin_s;
  logic supply_s, tog_s, tog_q;
  logic [1:0] pup_c;
  scs_sync #(.W(4)) u_cin (
    .i_clk(i_core_clk),
    .i_d({i_supply_ok, pup_r, nv_tog_r}),
    .o_q(cin_s)
  );
  assign {supply_s, pup_c, tog_s} = cin_s;

  // Programming cycle timer
  logic [31:0] nv_cnt_r;
  always_ff @(posedge i_core_clk) begin
    tog_q <= tog_s;
    if (!i_rstn) begin
      busy_c <= 1'b0;
      nv_cnt_r <= '0;
    end else if (tog_s ^ tog_q) begin
      busy_c <= 1'b1;
      nv_cnt_r <= '0;
    end else if (busy_c) begin
      if (nv_cnt_r >= NV_CYC - 1) begin
        busy_c <= 1'b0;
      end else begin
        nv_cnt_r <= nv_cnt_r + 32'h1;
      end
    end
  end

  // Delay code taken only once both bits have settled
  logic [1:0] pup_q_r, pup_hold_r;
  always_ff @(posedge i_core_clk) begin
    pup_q_r <= pup_c;
    if (pup_c == pup_q_r) begin
      pup_hold_r <= pup_c;
    end
  end

  // Power-on reset delay
  logic [31:0] por_cnt_r, por_dly;
  always_comb begin
    case (pup_hold_r)
      PUP_50: por_dly = POR_CYC_0;
      PUP_100: por_dly = POR_CYC_1;
      PUP_200: por_dly = POR_CYC_2;
      default: por_dly = POR_CYC_3;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn || !supply_s) begin
      o_reset_out <= 1'b1;
      por_cnt_r <= '0;
    end else if (o_reset_out) begin
      if (por_cnt_r >= por_dly - 1) begin
        o_reset_out <= 1'b0;
      end else begin
        por_cnt_r <= por_cnt_r + 32'h1;
      end
    end
  end

  // Bus edges
  logic scl_q, sda_q, start, stop, scl_rise, scl_fall;
  always_ff @(posedge i_link_clk) begin
    scl_q <= scl_s;
    sda_q <= sda_s;
  end
  assign start = scl_s && scl_q && sda_q && !sda_s;
  assign stop = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;

  // Register state
  logic wel_r, register_write_latch_r, f2_r, f3_r, nv_pend_r, busy_l;
  logic [7:0] cs_w, rd_byte;
  logic [7:0] mem_r [256];
  assign cs_w = {pup_r[1], f2_r, f3_r, o_protect, register_write_latch_r, wel_r, pup_r[0]};
  assign busy_l = nv_pend_r || busy_s;

  function automatic logic prot_hit(input logic [1:0] bp, input logic [7:0] a);
    case (bp)
      BP_NONE: prot_hit = 1'b0;
      BP_QTR: prot_hit = a >= QTR_BASE;
      BP_HALF: prot_hit = a >= HALF_BASE;
      default: prot_hit = 1'b1;
    endcase
  endfunction

  // Serial engine
  scs_state_e st_r, nxt_r;
  scs_tgt_e tgt_r, tgt_n;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r, tx_r, ptr_r, mem_wa_r, mem_wd_r, cr_data_r;
  logic mem_we_r, cr_pend_r, cr_got_r, cr_commit_r, register_write_latch_clr_r, wip_we_r;
  assign rd_byte = (tgt_r == TG_CR) ? cs_w : mem_r[ptr_r];
  always_comb begin
    if (shift_r[7:1] == ID_MEM) begin
      tgt_n = TG_MEM;
    end else if (shift_r[7:1] == ID_CR) begin
      tgt_n = TG_CR;
    end else if (shift_r[7:1] == ID_DCP) begin
      tgt_n = TG_DCP;
    end else begin
      tgt_n = TG_NONE;
    end
  end
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      st_r <= ST_IDLE;
      nxt_r <= ST_IDLE;
      tgt_r <= TG_NONE;
      bitcnt_r <= '0;
      shift_r <= '0;
      tx_r <= '0;
      ptr_r <= '0;
      o_sda_oe <= 1'b0;
      mem_we_r <= 1'b0;
      mem_wa_r <= '0;
      mem_wd_r <= '0;
      cr_pend_r <= 1'b0;
      cr_got_r <= 1'b0;
      cr_data_r <= '0;
      cr_commit_r <= 1'b0;
      register_write_latch_clr_r <= 1'b0;
      wip_we_r <= 1'b0;
    end else begin
      mem_we_r <= 1'b0;
      cr_commit_r <= 1'b0;
      register_write_latch_clr_r <= 1'b0;
      wip_we_r <= 1'b0;
      if (start) begin
        st_r <= ST_DEV;
        bitcnt_r <= '0;
        o_sda_oe <= 1'b0;
        cr_pend_r <= 1'b0;
      end else if (stop) begin
        st_r <= ST_IDLE;
        o_sda_oe <= 1'b0;
        cr_pend_r <= 1'b0;
        cr_commit_r <= cr_pend_r;
      end else if (scl_rise) begin
        case (st_r)
          ST_DEV, ST_ADDR, ST_WDATA: begin
            shift_r <= {shift_r[6:0], sda_s};
            bitcnt_r <= bitcnt_r + 4'h1;
          end
          ST_RACK: begin
            if (sda_s) begin
              st_r <= ST_WAIT;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_r)
          ST_DEV: begin
            if (bitcnt_r == BYTE_BITS) begin
              if (tgt_n != TG_NONE && !busy_l) begin
                o_sda_oe <= 1'b1;
                st_r <= ST_ACK;
                nxt_r <= shift_r[0] ? ST_RDATA : ST_ADDR;
                tgt_r <= tgt_n;
                cr_got_r <= 1'b0;
              end else begin
                st_r <= ST_WAIT;
              end
            end
          end
          ST_ADDR: begin
            if (bitcnt_r == BYTE_BITS) begin
              if (tgt_r == TG_CR && shift_r != CR_ADDR) begin
                st_r <= ST_WAIT;
              end else begin
                o_sda_oe <= 1'b1;
                st_r <= ST_ACK;
                nxt_r <= ST_WDATA;
                if (tgt_r == TG_MEM) begin
                  ptr_r <= shift_r;
                end
              end
            end
          end
          ST_WDATA: begin
            if (bitcnt_r == BYTE_BITS) begin
              st_r <= ST_WAIT;
              case (tgt_r)
                TG_MEM: begin
                  if (wel_r && !wp_s && !prot_hit(o_protect, ptr_r)) begin
                    o_sda_oe <= 1'b1;
                    st_r <= ST_ACK;
                    mem_we_r <= 1'b1;
                    mem_wa_r <= ptr_r;
                    mem_wd_r <= shift_r;
                    ptr_r <= {ptr_r[7:4], ptr_r[3:0] + PAGE_STEP};
                  end else if (prot_hit(o_protect, ptr_r)) begin
                    register_write_latch_clr_r <= 1'b1;
                  end
                end
                TG_DCP: begin
                  if (wel_r && o_protect == BP_NONE) begin
                    o_sda_oe <= 1'b1;
                    st_r <= ST_ACK;
                    wip_we_r <= 1'b1;
                    mem_wd_r <= shift_r;
                  end
                end
                default: begin
                  if (!cr_got_r && (wel_r || shift_r == WEL_SET)) begin
                    o_sda_oe <= 1'b1;
                    st_r <= ST_ACK;
                    cr_pend_r <= 1'b1;
                    cr_got_r <= 1'b1;
                    cr_data_r <= shift_r;
                  end else begin
                    cr_pend_r <= 1'b0;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            st_r <= nxt_r;
            bitcnt_r <= '0;
            o_sda_oe <= 1'b0;
            if (nxt_r == ST_RDATA) begin
              o_sda_oe <= !rd_byte[7];
              tx_r <= {rd_byte[6:0], 1'b0};
              bitcnt_r <= 4'h1;
              if (tgt_r == TG_MEM) begin
                ptr_r <= ptr_r + 8'h1;
              end
            end
          end
          ST_RDATA: begin
            if (bitcnt_r == BYTE_BITS) begin
              o_sda_oe <= 1'b0;
              st_r <= ST_RACK;
            end else begin
              o_sda_oe <= !tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
          ST_RACK: begin
            st_r <= ST_RDATA;
            o_sda_oe <= !rd_byte[7];
            tx_r <= {rd_byte[6:0], 1'b0};
            bitcnt_r <= 4'h1;
            if (tgt_r == TG_MEM) begin
              ptr_r <= ptr_r + 8'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge i_link_clk) begin
    o_sda <= 1'b0;
  end

  // Memory array
  always_ff @(posedge i_link_clk) begin
    if (mem_we_r) begin
      mem_r[mem_wa_r] <= mem_wd_r;
    end
  end

  // Wiper position
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      o_wiper_pos <= '0;
    end else if (wip_we_r) begin
      o_wiper_pos <= mem_wd_r;
    end
  end

  // Nonvolatile bits and programming cycle request
  logic nv_ok;
  assign nv_ok = cr_commit_r && wel_r && register_write_latch_r && !cr_data_r[B_REGISTER_WRITE_LATCH] && !wp_s;
  always_ff @(posedge i_link_clk) begin
    if (!lfac_n) begin
      o_protect <= BP_DEF;
      pup_r <= PUP_DEF;
      nv_tog_r <= 1'b0;
    end else if (nv_ok) begin
      o_protect <= {cr_data_r[B_BP_HI], cr_data_r[B_BP_LO]};
      pup_r <= {cr_data_r[B_PUP_HI], cr_data_r[B_PUP_LO]};
      nv_tog_r <= !nv_tog_r;
    end
  end
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      nv_pend_r <= 1'b0;
    end else if (nv_ok) begin
      nv_pend_r <= 1'b1;
    end else if (busy_s) begin
      nv_pend_r <= 1'b0;
    end
  end

  // Volatile bits
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      wel_r <= 1'b0;
      register_write_latch_r <= 1'b0;
      f2_r <= 1'b0;
      f3_r <= 1'b0;
    end else begin
      if (cr_commit_r) begin
        if (register_write_latch_r && wel_r) begin
          if (!cr_data_r[B_REGISTER_WRITE_LATCH]) begin
            register_write_latch_r <= 1'b0;
            wel_r <= cr_data_r[B_WEL];
            f2_r <= cr_data_r[B_F2] && fail2_s;
            f3_r <= cr_data_r[B_F3] && fail3_s;
          end
        end else if (cr_data_r == WEL_SET) begin
          wel_r <= 1'b1;
        end else if (cr_data_r == WEL_CLR) begin
          wel_r <= 1'b0;
        end else if (cr_data_r == REGISTER_WRITE_LATCH_SET && wel_r) begin
          register_write_latch_r <= 1'b1;
        end
      end
      if (register_write_latch_clr_r) begin
        register_write_latch_r <= 1'b0;
      end
      if (!fail2_s) begin
        f2_r <= 1'b0;
      end
      if (!fail3_s) begin
        f3_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      o_control_status <= '0;
    end else begin
      o_control_status <= cs_w;
    end
  end

  // Checks
  a_register_write_latch_needs_wel: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    $rose(register_write_latch_r) |-> $past(wel_r)) else $error("register latch set without write latch");
  a_flag_needs_fail: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    $rose(f2_r) |-> $past(fail2_s)) else $error("fail flag set while fail low");
  a_flag_drops: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    f3_r && !fail3_s |=> !f3_r) else $error("fail flag held after fail low");
  a_mem_guarded: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    mem_we_r |-> $past(wel_r) && !prot_hit(o_protect, mem_wa_r))
    else $error("write into protected or disabled array");
  a_wiper_locked: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    wip_we_r |-> o_protect == BP_NONE) else $error("wiper write while protected");
  a_nv_wp_block: assert property (@(posedge i_link_clk) disable iff (!lfac_n)
    $changed(pup_r) || $changed(o_protect) |-> $past(!wp_s) && $past(register_write_latch_r))
    else $error("nonvolatile bits changed while blocked");
  a_latch_no_cycle: assert property (@(posedge i_link_clk) disable iff (!lfac_n)
    cr_commit_r && !register_write_latch_r |=> $stable(nv_tog_r)) else $error("latch write started cycle");
  a_read_advance: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    scl_fall && st_r == ST_RACK && tgt_r == TG_MEM |=> ptr_r == $past(ptr_r) + 8'h1)
    else $error("read pointer did not advance");
  a_reset_held: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !supply_s |=> o_reset_out ##1 o_reset_out) else $error("reset released early");
endmodule // scs_supervisor

// file: tb/scs_master.sv
// Two-wire bus master model: drives clock and data, reads the data wire.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps
module scs_master (
  // Timing reference
  input wire logic i_clk,
  // Resolved data wire
  input wire logic i_sda_wire,
  // Bus drive, data released high
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic ph();
    repeat (8) @(posedge i_clk);
    #1;
  endtask
  task automatic start();
    o_sda = 1'b1;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda = 1'b0;
    ph();
    o_scl = 1'b0;
    ph();
  endtask
  task automatic stop();
    o_sda = 1'b0;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda = 1'b1;
    ph();
  endtask
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    ph();
    o_scl = 1'b1;
    ph();
    r = i_sda_wire;
    o_scl = 1'b0;
    ph();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~more, r);
  endtask
  task automatic hdr(input logic [7:0] id, input logic [7:0] ad, output logic ack);
    start();
    wbyte(id, ack);
    wbyte(ad, ack);
  endtask
endmodule // scs_master

// file: tb/scs_supervisor_test.sv
// Bench: reference model of the register and array, compared at each result.
// Assumes the master model in scs_master.sv and shortened count parameters.
`timescale 1ns/1ps
module scs_supervisor_test;
  import scs_pkg::*;
  localparam int P0 = 200;
  localparam int P1 = 400;
  localparam int P2 = 800;
  localparam int P3 = 1200;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rstn = 1'b0;
  logic frstn = 1'b0;
  logic wp = 1'b0;
  logic ok = 1'b1;
  logic f2in = 1'b0;
  logic f3in = 1'b0;
  logic scl, msda, sda_oe, sda_o, rout;
  logic [1:0] prot;
  logic [7:0] wpos, cs;
  wire sda_w = msda & ~(sda_oe & ~sda_o);
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] mem [256];
  logic [7:0] adr [4] = '{8'h7f, 8'h80, 8'hbf, 8'hc0};
  logic write_enable_latch, register_write_latch, f2, f3;
  logic [1:0] bp = 2'h0;
  logic [1:0] pup = 2'h1;
  logic [7:0] wexp = 8'h00;

  always #2.5 clk = ~clk;
  initial begin
    #0.7;
    forever #3 lclk = ~lclk;
  end

  scs_supervisor #(.POR_CYC_0(P0), .POR_CYC_1(P1), .POR_CYC_2(P2), .POR_CYC_3(P3),
    .NV_CYC(100)) dut (.i_core_clk(clk), .i_rstn(rstn), .i_factory_rstn(frstn),
    .i_link_clk(lclk), .i_scl(scl), .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_wp(wp), .i_supply_ok(ok), .i_second_fail_output(f2in),
    .i_third_fail_output(f3in), .o_reset_out(rout), .o_protect(prot),
    .o_wiper_pos(wpos), .o_control_status(cs));
  scs_master m (.i_clk(clk), .i_sda_wire(sda_w), .o_scl(scl), .o_sda(msda));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc_w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] cr_exp();
    return {pup[1], f2, f3, bp, register_write_latch, write_enable_latch, pup[0]};
  endfunction
  task automatic por_chk();
    int n;
    n = pup == 2'h0 ? P0 : pup == 2'h1 ? P1 : pup == 2'h2 ? P2 : P3;
    cyc_w(n - 60);
    chk({7'h0, rout}, 8'h01);
    cyc_w(120);
    chk({7'h0, rout}, 8'h00);
  endtask
  // Reset held long enough for the link side too
  task automatic pwr(input logic fac);
    rstn = 1'b0;
    ok = 1'b0;
    frstn = !fac;
    cyc_w(5);
    rstn = 1'b1;
    frstn = 1'b1;
    cyc_w(4);
    ok = 1'b1;
    {write_enable_latch, register_write_latch, f2, f3} = 4'h0;
    por_chk();
  endtask
  task automatic cr_chk();
    logic a;
    logic [7:0] d;
    m.hdr({ID_CR, 1'b0}, CR_ADDR, a);
    m.start();
    m.wbyte({ID_CR, 1'b1}, a);
    m.rbyte(1'b0, d);
    m.stop();
    chk(d, cr_exp());
    chk(cs, cr_exp());
    chk({6'h0, prot}, {6'h0, bp});
    cyc_w(20);
  endtask
  task automatic cr_cmd(input logic [7:0] d);
    logic a;
    logic nv;
    m.hdr({ID_CR, 1'b0}, CR_ADDR, a);
    m.wbyte(d, a);
    m.stop();
    nv = write_enable_latch && register_write_latch && !d[B_REGISTER_WRITE_LATCH];
    if (!write_enable_latch || d == WEL_SET || d == WEL_CLR || d == REGISTER_WRITE_LATCH_SET)
      chk({7'h0, a}, {7'h0, write_enable_latch || d == WEL_SET});
    if (!write_enable_latch) begin
      write_enable_latch = (d == WEL_SET);
    end else if (!register_write_latch) begin
      if (d == WEL_CLR) write_enable_latch = 1'b0;
      if (d == REGISTER_WRITE_LATCH_SET) register_write_latch = 1'b1;
    end else if (nv) begin
      register_write_latch = 1'b0;
      write_enable_latch = d[B_WEL];
      f2 = d[B_F2] & f2in;
      f3 = d[B_F3] & f3in;
      bp = {d[B_BP_HI], d[B_BP_LO]};
      pup = {d[B_PUP_HI], d[B_PUP_LO]};
    end
    cyc_w(nv ? 150 : 20);
  endtask
  task automatic mem_wr(input logic [7:0] ad, input int n);
    logic a;
    logic lock;
    logic [7:0] d;
    lock = bp == 2'h3 || (bp == BP_HALF && ad >= HALF_BASE) || (bp == BP_QTR && ad >= QTR_BASE);
    m.hdr({ID_MEM, 1'b0}, ad, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.wbyte(d, a);
      chk({7'h0, a}, {7'h0, write_enable_latch && !wp && !lock});
      if (write_enable_latch && !wp && !lock) mem[{ad[7:4], ad[3:0] + 4'(i)}] = d;
    end
    m.stop();
    if (lock && write_enable_latch && !wp) register_write_latch = 1'b0;
    cyc_w(150);
  endtask
  task automatic mem_rd(input logic [7:0] ad, input int n);
    logic a;
    logic [7:0] d;
    m.hdr({ID_MEM, 1'b0}, ad, a);
    m.start();
    m.wbyte({ID_MEM, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk(d, mem[8'(ad + i)]);
    end
    m.stop();
    cyc_w(20);
  endtask
  task automatic wip_wr();
    logic a;
    logic [7:0] d;
    d = 8'($urandom);
    m.hdr({ID_DCP, 1'b0}, 8'h00, a);
    m.wbyte(d, a);
    m.stop();
    chk({7'h0, a}, {7'h0, write_enable_latch && bp == BP_NONE});
    if (write_enable_latch && bp == BP_NONE) wexp = d;
    cyc_w(150);
    chk(wpos, wexp);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(15022));
    pwr(1'b1);
    cr_chk();
    mem_wr(8'h10, 1);
    cr_cmd(REGISTER_WRITE_LATCH_SET);
    cr_cmd(WEL_SET);
    mem_wr(8'hf0, 16);
    cr_cmd(8'h18);
    cr_chk();
    mem_wr(8'h0e, 4);
    mem_rd(8'hfe, 4);
    wip_wr();
    foreach (adr[j]) mem_wr(adr[j], 1);
    // Walk all protect codes, ending with none
    for (int i = 1; i <= 4; i++) begin
      cr_cmd(REGISTER_WRITE_LATCH_SET);
      cr_cmd({1'b1, 2'h0, 2'(i), 1'b0, 1'b1, 1'b1});
      cr_cmd(REGISTER_WRITE_LATCH_SET);
      foreach (adr[j]) mem_wr(adr[j], 1);
      mem_rd(8'h7f, 2);
      mem_rd(8'hbf, 2);
      wip_wr();
      cr_chk();
    end
    wp = 1'b1;
    mem_wr(8'h10, 1);
    wp = 1'b0;
    cr_cmd(8'he3);
    cr_chk();
    {f2in, f3in} = 2'h3;
    cr_cmd(REGISTER_WRITE_LATCH_SET);
    cr_cmd(8'he3);
    cr_chk();
    {f2in, f3in} = 2'h0;
    cyc_w(20);
    {f2, f3} = 2'h0;
    cr_chk();
    pwr(1'b0);
    cr_chk();
    end_of_test();
  end
endmodule // scs_supervisor_test
